// *** hw/csq_channel_sequence_select.sv ***
/*
 * Channel sequence selection and result coding for a four channel
 * simultaneous sampling converter.
 * Assumes host strobes and pins are synchronous to clock and that the
 * converter core presents an offset binary code per channel.
 */
`timescale 1ns/100ps

module csq_channel_sequence_select
    import csq_pkg::*;
#(
    parameter bit BIPOLAR = 1'b1,
    parameter int CONV_CYCLES = CSQ_CONV_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] hw_channel_pick_pins,
    input wire logic seq_source_sel,
    input wire logic conversion_trigger_n,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [3:0] low_data_lines_in,
    output logic [3:0] low_data_lines_out,
    output logic low_data_lines_oe,
    input wire logic [3:0][11:0] core_codes,
    output logic [3:0] latched_selection,
    output logic sequence_busy,
    output logic result_valid,
    output csq_result_type result_word
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // lowest selected channel at or above start, bit 2 set when found
    function automatic logic [2:0] next_channel(
        input logic [3:0] mask,
        input logic [2:0] start
    );
        logic [2:0] pick;
        pick = 3'h0;
        for (int i = CSQ_CHANNELS - 1; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= start)) begin
                pick = {1'b1, 2'(i)};
            end
        end
        return pick;
    endfunction : next_channel

    function automatic logic [11:0] code_of(input logic [11:0] raw);
        return BIPOLAR ? (raw ^ CSQ_SIGN_FLIP) : raw;
    endfunction : code_of

    // ----------------------------------------
    // host write path
    // ----------------------------------------
    csq_host_type host;
    csq_host_type host_prev;
    logic [3:0] channel_sequence_select;
    logic [3:0] write_stage;
    logic write_armed;

    assign host = '{chip_select_n: chip_select_n, write_strobe_n: write_strobe_n,
                    read_strobe_n: read_strobe_n, data: low_data_lines_in};

    wire write_window = !host.chip_select_n && !host.write_strobe_n
                        && host.read_strobe_n;
    wire write_rise = host_prev.write_strobe_n == 1'b0 && host.write_strobe_n;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            host_prev <= '{1'b1, 1'b1, 1'b1, CSQ_SELECT_RESET};
        end else begin
            host_prev <= host;
        end
    end

    // staging follows the lines while the write window is open and keeps them once it closes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            write_armed <= 1'b0;
        end else if (write_window) begin
            write_armed <= 1'b1;
        end else if (write_rise) begin
            write_armed <= 1'b0;
        end
    end

    genvar lane;
    generate
        for (lane = 0; lane < CSQ_CHANNELS; lane++) begin : g_lane
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    write_stage[lane] <= 1'b0;
                    channel_sequence_select[lane] <= 1'b0;
                end else begin
                    if (write_window) begin
                        write_stage[lane] <= host.data[lane];
                    end
                    if (write_rise && write_armed) begin
                        channel_sequence_select[lane] <= write_stage[lane];
                    end
                end
            end
        end
    endgenerate

    // data lines are never driven: output held at CSQ_SELECT_RESET, enable held low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            low_data_lines_out <= CSQ_SELECT_RESET;
            low_data_lines_oe <= 1'b0;
        end else begin
            low_data_lines_out <= CSQ_SELECT_RESET;
            low_data_lines_oe <= 1'b0;
        end
    end

    // ----------------------------------------
    // source mux and trigger edge
    // ----------------------------------------
    logic trigger_prev;
    wire [3:0] source_selection = seq_source_sel ? channel_sequence_select
                                                 : hw_channel_pick_pins;
    wire trigger_rise = !trigger_prev && conversion_trigger_n;
    wire [2:0] first_pick = next_channel(source_selection, 3'h0);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            trigger_prev <= 1'b1;
        end else begin
            trigger_prev <= conversion_trigger_n;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    csq_state_type state;
    csq_state_type next_state;
    logic [1:0] channel;
    logic [7:0] count;
    wire count_done = count == 8'(CONV_CYCLES - 1);
    wire [2:0] later_pick = next_channel(latched_selection, 3'(channel) + 3'h1);
    wire [11:0] raw_code = core_codes[channel];

    always_comb begin
        next_state = state;
        case (state)
            CSQ_IDLE: begin
                if (trigger_rise && first_pick[2]) begin
                    next_state = CSQ_CONVERT;
                end
            end
            CSQ_CONVERT: begin
                if (trigger_rise) begin
                    next_state = first_pick[2] ? CSQ_CONVERT : CSQ_IDLE;
                end else if (count_done && !later_pick[2]) begin
                    next_state = CSQ_IDLE;
                end
            end
            default: begin
                next_state = CSQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= CSQ_IDLE;
            sequence_busy <= 1'b0;
        end else begin
            state <= next_state;
            sequence_busy <= next_state == CSQ_CONVERT;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latched_selection <= CSQ_SELECT_RESET;
            channel <= 2'h0;
            count <= CSQ_COUNT_RESET;
        end else if (trigger_rise) begin
            latched_selection <= source_selection;
            channel <= first_pick[1:0];
            count <= CSQ_COUNT_RESET;
        end else if (state == CSQ_CONVERT) begin
            if (count_done) begin
                channel <= later_pick[1:0];
                count <= CSQ_COUNT_RESET;
            end else begin
                count <= count + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_valid <= 1'b0;
            result_word <= '{2'h0, CSQ_CODE_RESET};
        end else begin
            result_valid <= state == CSQ_CONVERT && count_done && !trigger_rise;
            if (state == CSQ_CONVERT && count_done && !trigger_rise) begin
                result_word <= '{channel, code_of(raw_code)};
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic first_of_seq;
    logic [1:0] last_channel;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            first_of_seq <= 1'b1;
            last_channel <= 2'h0;
        end else if (trigger_rise) begin
            first_of_seq <= 1'b1;
        end else if (result_valid) begin
            first_of_seq <= 1'b0;
            last_channel <= result_word.channel;
        end
    end

    source_mux_a: assert property (@(posedge clock) disable iff (!rst_b)
        trigger_rise && !seq_source_sel
        |=> latched_selection == $past(hw_channel_pick_pins))
        else $error("pin selection not used when source low");

    reg_source_a: assert property (@(posedge clock) disable iff (!rst_b)
        trigger_rise && seq_source_sel
        |=> latched_selection == $past(channel_sequence_select))
        else $error("register selection not used when source high");

    sel_latch_a: assert property (@(posedge clock) disable iff (!rst_b)
        trigger_rise |=> latched_selection == ($past(seq_source_sel) ?
            $past(channel_sequence_select) : $past(hw_channel_pick_pins)))
        else $error("selection not latched at trigger");

    sel_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        sequence_busy && !trigger_rise |=> $stable(latched_selection))
        else $error("latched selection moved mid sequence");

    reg_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        write_window ##1 write_rise |=> channel_sequence_select == $past(write_stage))
        else $error("register not loaded on strobe rise");

    chan_member_a: assert property (@(posedge clock) disable iff (!rst_b)
        result_valid |-> latched_selection[result_word.channel])
        else $error("result from unselected channel");

    ascend_order_a: assert property (@(posedge clock) disable iff (!rst_b)
        result_valid && !first_of_seq |-> result_word.channel > last_channel)
        else $error("channels out of ascending order");

    empty_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
        trigger_rise && source_selection == 4'h0 |=> !sequence_busy ##1 !result_valid)
        else $error("empty selection started a sequence");

    code_form_a: assert property (@(posedge clock) disable iff (!rst_b)
        result_valid |-> result_word.code == ($past(raw_code) ^
            (BIPOLAR ? CSQ_SIGN_FLIP : 12'h000)))
        else $error("result coding wrong");

    uni_code_a: assert property (@(posedge clock) disable iff (!rst_b)
        result_valid && !BIPOLAR |-> result_word.code == $past(raw_code))
        else $error("unipolar result not straight binary");

    stage_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        !write_window |=> $stable(write_stage))
        else $error("data lines taken outside write window");

    refuse_load_a: assert property (@(posedge clock) disable iff (!rst_b)
        write_rise && !write_armed |=> $stable(channel_sequence_select))
        else $error("register loaded without write window");

    no_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
        !low_data_lines_oe)
        else $error("data lines driven by this block");

    lines_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
        low_data_lines_out == CSQ_SELECT_RESET)
        else $error("data line output not quiet");

    restart_seq_a: assert property (@(posedge clock) disable iff (!rst_b)
        trigger_rise && first_pick[2] |=> sequence_busy && !result_valid)
        else $error("new trigger did not restart the sequence");

    idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
        !sequence_busy |=> !result_valid)
        else $error("result while no sequence runs");

endmodule : csq_channel_sequence_select

// *** hw/csq_pkg.sv ***
/*
 * Shared constants and types for the channel sequence select block.
 * Assumes a single 125 MHz clock domain and an external converter core.
 */
package csq_pkg;

    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int CSQ_CHANNELS = 4;
    localparam int CSQ_CODE_BITS = 12;
    localparam int CSQ_CLOCK_PERIOD_PS = 8000;
    localparam int CSQ_CONV_TIME_PS = 1650000;
    // least time, rounded up to whole cycles
    localparam int CSQ_CONV_CYCLES =
        (CSQ_CONV_TIME_PS + CSQ_CLOCK_PERIOD_PS - 1) / CSQ_CLOCK_PERIOD_PS;
    localparam int CSQ_COUNT_BITS = 8;

    // ----------------------------------------
    // reset values and sign flip mask
    // ----------------------------------------
    localparam logic [3:0] CSQ_SELECT_RESET = 4'h0;
    localparam logic [11:0] CSQ_CODE_RESET = 12'h000;
    localparam logic [11:0] CSQ_SIGN_FLIP = 12'h800;
    localparam logic [7:0] CSQ_COUNT_RESET = 8'h00;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        CSQ_IDLE = 2'b01,
        CSQ_CONVERT = 2'b10
    } csq_state_type;

    typedef struct packed {
        logic [1:0] channel;
        logic [11:0] code;
    } csq_result_type;

    // host write strobes and data lines, sampled each clock
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic read_strobe_n;
        logic [3:0] data;
    } csq_host_type;

endpackage : csq_pkg

// *** testbench/csq_host_model.sv ***
/* host processor model for the channel select register write cycle
   assumes the bench calls write_reg and owns the clock */
`timescale 1ns/100ps
module csq_host_model (
    input wire logic clock,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic [3:0] data
);
    initial begin
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        data = 4'h5;
    end
    // one write; rd_level low breaks the window on purpose
    task automatic write_reg(input logic [3:0] value, input logic rd_level);
        @(posedge clock);
        #1;
        chip_select_n = 1'b0;
        write_strobe_n = 1'b0;
        read_strobe_n = rd_level;
        data = value;
        @(posedge clock);
        #1;
        write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        data = ~value;
    endtask : write_reg
endmodule : csq_host_model

// *** testbench/tb.sv ***
/* self-checking bench for the channel sequence select block
   assumes csq_pkg and the host model are compiled first */
`timescale 1ns/100ps
module tb;
    import csq_pkg::*;
    localparam int CONV = 4;
    logic clock, rst_b, src, trig_n, cs_n, wr_n, rd_n, oe, busy, valid;
    logic [3:0] pins, latched, data, dout;
    logic [3:0][11:0] codes = {12'h123, 12'h7FE, 12'h801, 12'h0FF};
    csq_result_type word, word_uni;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    csq_host_model csq_host_model_i (.clock(clock), .chip_select_n(cs_n),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .data(data));
    csq_channel_sequence_select #(.BIPOLAR(1'b1), .CONV_CYCLES(CONV))
    csq_channel_sequence_select_i (.clock(clock), .rst_b(rst_b),
        .hw_channel_pick_pins(pins), .seq_source_sel(src),
        .conversion_trigger_n(trig_n), .chip_select_n(cs_n),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .low_data_lines_in(data),
        .low_data_lines_out(dout), .low_data_lines_oe(oe), .core_codes(codes),
        .latched_selection(latched), .sequence_busy(busy),
        .result_valid(valid), .result_word(word));
    csq_channel_sequence_select #(.BIPOLAR(1'b0), .CONV_CYCLES(CONV))
    csq_channel_sequence_select_i2 (.clock(clock), .rst_b(rst_b),
        .hw_channel_pick_pins(pins), .seq_source_sel(src),
        .conversion_trigger_n(trig_n), .chip_select_n(cs_n),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .low_data_lines_in(data),
        .low_data_lines_out(), .low_data_lines_oe(), .core_codes(codes),
        .latched_selection(), .sequence_busy(), .result_valid(),
        .result_word(word_uni));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            give_verdict();
        end
    end

    // ----
    // helpers
    // ----
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic chk_sel(input logic [3:0] got, input logic [3:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk_sel
    task automatic chk_word(input csq_result_type got, input csq_result_type exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: result got %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic fire(input logic [3:0] exp);
        trig_n = 1'b0;
        step(1);
        trig_n = 1'b1;
        step(2);
        chk_sel(latched, exp, "latched");
        chk_sel({3'h0, busy}, {3'h0, exp != 4'h0}, "busy");
    endtask : fire
    task automatic collect(input logic [3:0] exp);
        for (int ch = 0; ch < 4; ch++) begin
            if (exp[ch]) begin
                for (int n = 0; n < 3 * CONV && valid !== 1'b1; n++) step(1);
                chk_sel({3'h0, valid}, 4'h1, "valid");
                chk_word(word, '{2'(ch), codes[ch] ^ CSQ_SIGN_FLIP});
                chk_word(word_uni, '{2'(ch), codes[ch]});
                step(1);
                chk_sel({3'h0, valid}, 4'h0, "pulse");
            end
        end
        chk_sel({3'h0, busy}, 4'h0, "busy end");
    endtask : collect

    // ----
    // scenarios
    // ----
    task automatic t_empty();
        src = 1'b1;
        fire(4'h0);
        for (int n = 0; n < 3 * CONV; n++) begin
            chk_sel({2'h0, valid, busy}, 4'h0, "idle");
            step(1);
        end
        $display("test empty done");
    endtask : t_empty
    task automatic t_pins();
        csq_host_model_i.write_reg(4'h2, 1'b1);
        src = 1'b0;
        pins = 4'hD;
        fire(4'hD);
        collect(4'hD);
        pins = 4'hF;
        fire(4'hF);
        collect(4'hF);
        $display("test pins done");
    endtask : t_pins
    task automatic t_window();
        csq_host_model_i.write_reg(4'h6, 1'b1);
        csq_host_model_i.write_reg(4'h9, 1'b0);
        src = 1'b1;
        fire(4'h6);
        collect(4'h6);
        chk_sel({oe, 3'h0}, 4'h0, "enable");
        chk_sel(dout, 4'h0, "drive");
        $display("test window done");
    endtask : t_window
    task automatic t_hold();
        csq_host_model_i.write_reg(4'hA, 1'b1);
        fire(4'hA);
        pins = 4'h1;
        csq_host_model_i.write_reg(4'h3, 1'b1);
        collect(4'hA);
        chk_sel(latched, 4'hA, "held");
        fire(4'h3);
        collect(4'h3);
        src = 1'b0;
        fire(4'h1);
        collect(4'h1);
        $display("test hold done");
    endtask : t_hold
    task automatic t_restart();
        src = 1'b0;
        pins = 4'hF;
        fire(4'hF);
        pins = 4'h2;
        fire(4'h2);
        collect(4'h2);
        pins = 4'hF;
        fire(4'hF);
        rst_b = 1'b0;
        step(2);
        chk_sel(latched, 4'h0, "reset latch");
        chk_sel({2'h0, valid, busy}, 4'h0, "reset quiet");
        rst_b = 1'b1;
        src = 1'b1;
        step(1);
        fire(4'h0);
        $display("test restart done");
    endtask : t_restart

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial begin
        pins = 4'h0;
        src = 1'b1;
        trig_n = 1'b1;
        rst_b = 1'b0;
        step(5);
        rst_b = 1'b1;
        step(1);
        t_empty();
        t_pins();
        t_window();
        t_hold();
        t_restart();
        give_verdict();
    end
endmodule : tb
